/* bench/scmg_chk_assertions.sv */
// Purpose: concurrent checks on the clock mode guard ports
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   bound to scmg_top after the module
module scmg_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic hw_irq,
    input logic wait_req,
    input logic cpu_clk_en,
    input logic main_osc_on,
    input logic periph_clk_on,
    input logic stop_mode,
    input logic wait_mode,
    input logic osc_stop_reset,
    input logic osc_detect_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // apb answer timing
    a_apb_zero_wait: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    // stop and wait modes
    a_stop_oscs_off: assert property (
        stop_mode && $past(stop_mode) |-> !main_osc_on && !periph_clk_on && !cpu_clk_en)
        else $error("clock running in stop");
    a_stop_irq_exit: assert property (stop_mode && hw_irq |=> !stop_mode)
        else $error("stop not left on interrupt");
    a_wait_irq_exit: assert property (wait_mode && hw_irq |=> !wait_mode)
        else $error("wait not left on interrupt");
    a_wait_entry: assert property (
        wait_req && !hw_irq && !stop_mode && !osc_stop_reset |=> wait_mode)
        else $error("wait not entered");
    // detection responses
    a_detrst_sticky: assert property (osc_stop_reset |=> osc_stop_reset)
        else $error("detection reset released");
    a_detrst_halted: assert property (
        osc_stop_reset && $past(osc_stop_reset) |-> !cpu_clk_en && !osc_detect_irq)
        else $error("activity during detection reset");
    a_irq_suppressed: assert property (osc_detect_irq |=> !osc_detect_irq [*8])
        else $error("repeated detection interrupt");

    // main scenarios reached
    c_stop_exit: cover property (stop_mode && hw_irq);
    c_det_irq: cover property (osc_detect_irq);
    c_det_rst: cover property (osc_stop_reset);
    c_bad_addr: cover property (pslverr);
endmodule

bind scmg_top scmg_chk scmg_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .hw_irq(hw_irq), .wait_req(wait_req), .cpu_clk_en(cpu_clk_en),
    .main_osc_on(main_osc_on), .periph_clk_on(periph_clk_on), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .osc_stop_reset(osc_stop_reset), .osc_detect_irq(osc_detect_irq));

/* bench/tb_scmg_top.sv */
// Purpose: directed tests of the clock mode guard
// Assumes: zero-wait apb slave, main oscillator pin toggled at 10 mhz
// Notes:   detection reset scenario runs last
`include "scmg_regs.vh"
module tb_scmg_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic main_osc_input = 0, wait_req = 0, hw_irq = 0, osc_run = 1, rerr = 0;
    logic pready, pslverr, cpu_clk_en, periph_src_onchip, periph_clk_on, main_osc_on, sub_osc_on;
    logic onchip_osc_on, pll_run, stop_mode, wait_mode, osc_stop_reset, osc_detect_irq;
    logic [1:0] cpu_src;
    int failures = 0, tests_run = 0;

    // clocks: pclk 40 mhz, oscillator pin 10 mhz while running
    always #12.5 pclk = ~pclk;
    always #50 main_osc_input = osc_run ? ~main_osc_input : main_osc_input;

    scmg_top scmg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .main_osc_input(main_osc_input), .wait_req(wait_req), .hw_irq(hw_irq),
        .cpu_clk_en(cpu_clk_en), .cpu_src(cpu_src), .periph_src_onchip(periph_src_onchip),
        .periph_clk_on(periph_clk_on), .main_osc_on(main_osc_on), .sub_osc_on(sub_osc_on),
        .onchip_osc_on(onchip_osc_on), .pll_run(pll_run), .stop_mode(stop_mode),
        .wait_mode(wait_mode), .osc_stop_reset(osc_stop_reset), .osc_detect_irq(osc_detect_irq));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        chk("apb ready", 1, n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h000000, exp}, rdat);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic period(input logic [7:0] c0, input logic [7:0] c1, input int exp);
        int n;
        wr(`SCMG_OFF_CC0, c0);
        wr(`SCMG_OFF_CC1, c1);
        tick(40);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        n = 0;
        do begin
            tick(1);
            n++;
        end while (cpu_clk_en !== 1'b1 && n < 40);
        chk("cpu tick period", exp, n);
    endtask

    task automatic t_reset_values;
        rd(`SCMG_OFF_CC0, `SCMG_CC0_RST, "cc0 reset");
        rd(`SCMG_OFF_CC1, `SCMG_CC1_RST, "cc1 reset");
        rd(`SCMG_OFF_DET, `SCMG_DET_RST, "det reset");
        rd(`SCMG_OFF_PLL, `SCMG_PLL_RST, "pll reset");
        rd(`SCMG_OFF_PM2, `SCMG_PM2_RST, "pm2 reset");
        rd(`SCMG_OFF_STAT, 8'h00, "status reset");
        apb(1'b0, 8'h1c, 8'h00);
        chk("unmapped error", 1, rerr);
        chk("unmapped data", 0, rdat);
        $display("done reset values");
    endtask

    task automatic t_divider;
        period(8'h40, 8'h00, 8);
        period(8'h00, 8'h00, 1);
        period(8'h00, 8'h40, 2);
        period(8'h00, 8'h80, 4);
        period(8'h00, 8'hc0, 16);
        wr(`SCMG_OFF_CC1, 8'h00);
        $display("done divider");
    endtask

    task automatic t_main_stop;
        int n;
        wr(`SCMG_OFF_CC0, 8'h20);
        rd(`SCMG_OFF_CC0, 8'h60, "stop forces div8");
        tick(1);
        chk("main osc off", 0, main_osc_on);
        osc_run = 0;
        n = 0;
        repeat (120) begin
            tick(1);
            if (osc_detect_irq === 1'b1 || osc_stop_reset === 1'b1) n++;
        end
        chk("disabled detection quiet", 0, n);
        osc_run = 1;
        wr(`SCMG_OFF_CC0, 8'h00);
        tick(1);
        chk("main osc on", 1, main_osc_on);
        $display("done main stop");
    endtask

    task automatic t_sub;
        wr(`SCMG_OFF_CC0, 8'h80);
        rd(`SCMG_OFF_CC0, 8'h00, "sub select refused");
        wr(`SCMG_OFF_CC0, 8'h10);
        tick(1);
        chk("sub osc on", 1, sub_osc_on);
        wr(`SCMG_OFF_CC0, 8'h90);
        tick(1);
        chk("sub source", `SCMG_SRC_SUB, cpu_src);
        wr(`SCMG_OFF_CC0, 8'h10);
        tick(1);
        chk("main source", `SCMG_SRC_MAIN, cpu_src);
        wr(`SCMG_OFF_CC0, 8'h00);
        tick(1);
        chk("sub osc off", 0, sub_osc_on);
        $display("done sub clock");
    endtask

    task automatic t_pll;
        wr(`SCMG_OFF_PLL, 8'h80);
        wr(`SCMG_OFF_CC1, 8'h02);
        tick(1);
        chk("pll source", `SCMG_SRC_PLL, cpu_src);
        chk("pll running", 1, pll_run);
        wr(`SCMG_OFF_CC0, 8'h10);
        wr(`SCMG_OFF_CC0, 8'h90);
        rd(`SCMG_OFF_CC0, 8'h10, "sub refused in pll");
        wr(`SCMG_OFF_CC1, 8'h00);
        wr(`SCMG_OFF_CC0, 8'h00);
        wr(`SCMG_OFF_DET, 8'h02);
        tick(1);
        chk("on-chip source", `SCMG_SRC_ONCHIP, cpu_src);
        wr(`SCMG_OFF_CC1, 8'h02);
        rd(`SCMG_OFF_CC1, 8'h00, "pll refused from on-chip");
        wr(`SCMG_OFF_CC0, 8'h40);
        wr(`SCMG_OFF_DET, 8'h00);
        wr(`SCMG_OFF_PLL, 8'h00);
        tick(1);
        chk("main source", `SCMG_SRC_MAIN, cpu_src);
        $display("done pll and on-chip");
    endtask

    task automatic t_lock;
        wr(`SCMG_OFF_PM2, 8'h02);
        rd(`SCMG_OFF_PM2, 8'h00, "pm2 guarded");
        wr(`SCMG_OFF_PRC, 8'h02);
        wr(`SCMG_OFF_PM2, 8'h02);
        wr(`SCMG_OFF_PRC, 8'h00);
        rd(`SCMG_OFF_PM2, 8'h02, "lock armed");
        wr(`SCMG_OFF_CC0, 8'h04);
        rd(`SCMG_OFF_CC0, 8'h00, "cc0 locked");
        wr(`SCMG_OFF_CC1, 8'h01);
        tick(1);
        chk("no stop when locked", 0, stop_mode);
        wr(`SCMG_OFF_PLL, 8'h80);
        rd(`SCMG_OFF_PLL, 8'h00, "pll locked");
        wr(`SCMG_OFF_DET, 8'h01);
        rd(`SCMG_OFF_DET, 8'h00, "det locked");
        wr(`SCMG_OFF_PRC, 8'h02);
        wr(`SCMG_OFF_PM2, 8'h00);
        wr(`SCMG_OFF_PRC, 8'h00);
        wr(`SCMG_OFF_CC0, 8'h04);
        rd(`SCMG_OFF_CC0, 8'h04, "cc0 unlocked");
        wr(`SCMG_OFF_CC0, 8'h00);
        $display("done clock lock");
    endtask

    task automatic t_stop_wait;
        wr(`SCMG_OFF_CC1, 8'h01);
        tick(1);
        chk("stop entered", 1, stop_mode);
        rd(`SCMG_OFF_STAT, 8'h01, "status stop");
        @(posedge pclk);
        hw_irq <= 1'b1;
        @(posedge pclk);
        hw_irq <= 1'b0;
        tick(1);
        chk("stop left", 0, stop_mode);
        rd(`SCMG_OFF_CC0, 8'h40, "div8 after stop");
        @(posedge pclk);
        wait_req <= 1'b1;
        @(posedge pclk);
        wait_req <= 1'b0;
        tick(1);
        chk("wait entered", 1, wait_mode);
        chk("periph on in wait", 1, periph_clk_on);
        @(posedge pclk);
        hw_irq <= 1'b1;
        @(posedge pclk);
        hw_irq <= 1'b0;
        tick(1);
        chk("wait left", 0, wait_mode);
        $display("done stop and wait");
    endtask

    task automatic t_detect_irq;
        int n;
        wr(`SCMG_OFF_DET, 8'h81);
        osc_run = 0;
        n = 0;
        while (osc_detect_irq !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("stop interrupt", 1, n < 200);
        tick(2);
        chk("fallback source", `SCMG_SRC_ONCHIP, cpu_src);
        chk("periph on-chip", 1, periph_src_onchip);
        chk("on-chip osc on", 1, onchip_osc_on);
        rd(`SCMG_OFF_DET, 8'h8f, "flags after stop");
        osc_run = 1;
        n = 0;
        repeat (200) begin
            tick(1);
            if (osc_detect_irq === 1'b1) n++;
        end
        chk("irq held off", 0, n);
        rd(`SCMG_OFF_DET, 8'h87, "flags after restart");
        wr(`SCMG_OFF_DET, 8'h86);
        wr(`SCMG_OFF_DET, 8'h00);
        rd(`SCMG_OFF_DET, 8'h00, "flags cleared");
        $display("done detect interrupt");
    endtask

    task automatic t_detect_reset;
        int n;
        wr(`SCMG_OFF_DET, 8'h01);
        osc_run = 0;
        n = 0;
        while (osc_stop_reset !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("detection reset", 1, n < 200);
        tick(30);
        chk("reset held", 1, osc_stop_reset);
        @(posedge pclk);
        presetn <= 1'b0;
        osc_run = 1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk("reset released", 0, osc_stop_reset);
        rd(`SCMG_OFF_CC0, `SCMG_CC0_RST, "cc0 after reset");
        $display("done detect reset");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_divider();
        t_main_stop();
        t_sub();
        t_pll();
        t_lock();
        t_stop_wait();
        t_detect_irq();
        t_detect_reset();
        end_of_test();
    end

    // watchdog
    initial begin
        #800000;
        failures++;
        $display("BAD watchdog expected end seen hang");
        end_of_test();
    end
endmodule

/* shared/scmg_regs.vh */
// Purpose: register map, field positions and timing for the clock mode guard
// Assumes: 8-bit apb offsets, 8-bit registers in the low byte of each word
// Notes:   all figures used by the logic are named here
`ifndef SCMG_REGS_VH
`define SCMG_REGS_VH
// register byte offsets
`define SCMG_OFF_CC0     8'h00
`define SCMG_OFF_CC1     8'h04
`define SCMG_OFF_DET     8'h08
`define SCMG_OFF_PLL     8'h0c
`define SCMG_OFF_PM2     8'h10
`define SCMG_OFF_PRC     8'h14
`define SCMG_OFF_STAT    8'h18
// clock_ctrl_0 fields
`define SCMG_CC0_PWAIT   2
`define SCMG_CC0_SUBEN   4
`define SCMG_CC0_MSTOP   5
`define SCMG_CC0_DIV8    6
`define SCMG_CC0_SUBSEL  7
// clock_ctrl_1 fields
`define SCMG_CC1_STOP    0
`define SCMG_CC1_PLLSRC  1
`define SCMG_CC1_DIVLO   6
`define SCMG_CC1_DIVHI   7
// osc_detect_ctrl fields
`define SCMG_DET_EN      0
`define SCMG_DET_ONCHIP  1
`define SCMG_DET_FLAG    2
`define SCMG_DET_MSTP    3
`define SCMG_DET_RESP    7
// pll_ctrl, processor_mode_2, write_protect_ctrl fields
`define SCMG_PLL_ON      7
`define SCMG_PM2_LOCK    1
`define SCMG_PRC_UNLK    1
// status fields
`define SCMG_ST_STOP     0
`define SCMG_ST_WAIT     1
// bits frozen while clock_lock is set
`define SCMG_CC0_LKMASK  8'ha4
`define SCMG_CC1_LKMASK  8'h03
`define SCMG_DET_LKMASK  8'h01
// reset values
`define SCMG_CC0_RST     8'h40
`define SCMG_CC1_RST     8'h00
`define SCMG_DET_RST     8'h00
`define SCMG_PLL_RST     8'h00
`define SCMG_PM2_RST     8'h00
`define SCMG_PRC_RST     8'h00
// cpu clock source codes
`define SCMG_SRC_MAIN    2'h0
`define SCMG_SRC_PLL     2'h1
`define SCMG_SRC_ONCHIP  2'h2
`define SCMG_SRC_SUB     2'h3
// divider terminal counts (divisor minus one)
`define SCMG_DIV1_TC     4'h0
`define SCMG_DIV2_TC     4'h1
`define SCMG_DIV4_TC     4'h3
`define SCMG_DIV8_TC     4'h7
`define SCMG_DIV16_TC    4'hf
// timing: pclk rate and main oscillator silence limit
`define SCMG_PCLK_MHZ    40
`define SCMG_STOP_NS     1000
`define SCMG_STOP_CYC    ((`SCMG_STOP_NS * `SCMG_PCLK_MHZ) / 1000)
`endif

/* verilog/scmg_cpu_div.v */
// Purpose: cpu clock enable divider
// Assumes: one pclk domain, code is {div8, hi, lo}
// Notes:   tick is a one-cycle enable, held low while run is low
`include "scmg_regs.vh"
module scmg_cpu_div (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       run,
    input  wire [2:0] code,
    output reg        tick
);
    reg  [3:0] cnt_r;
    reg  [3:0] tc;

    // ratio decode, div8 overrides the field
    always @* begin
        case (code)
            3'h0:    tc = `SCMG_DIV1_TC;
            3'h1:    tc = `SCMG_DIV2_TC;
            3'h2:    tc = `SCMG_DIV4_TC;
            3'h3:    tc = `SCMG_DIV16_TC;
            default: tc = `SCMG_DIV8_TC;
        endcase
    end

    // free counter, pulse at terminal count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
            tick  <= 1'b0;
        end else if (!run) begin
            cnt_r <= 4'h0;
            tick  <= 1'b0;
        end else if (cnt_r >= tc) begin
            cnt_r <= 4'h0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            tick  <= 1'b0;
        end
    end
endmodule

/* verilog/scmg_osc_mon.v */
// Purpose: main oscillator stop and restart watcher
// Assumes: osc_in is asynchronous, at least 2 mhz when running
// Notes:   stop_evt and restart_evt are one-cycle pulses
`include "scmg_regs.vh"
module scmg_osc_mon (
    input  wire pclk,
    input  wire presetn,
    input  wire osc_in,
    output reg  stop_evt,
    output reg  restart_evt
);
    reg        s1_r;
    reg        s2_r;
    reg        s3_r;
    reg        dead_r;
    reg  [7:0] gap_r;
    wire       edge_seen = s2_r ^ s3_r;

    // two-stage sync, third stage for edge compare
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= osc_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // silence counter and stopped state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r       <= 8'h00;
            dead_r      <= 1'b0;
            stop_evt    <= 1'b0;
            restart_evt <= 1'b0;
        end else begin
            stop_evt    <= 1'b0;
            restart_evt <= 1'b0;
            if (edge_seen) begin
                gap_r <= 8'h00;
                if (dead_r) begin
                    dead_r      <= 1'b0;
                    restart_evt <= 1'b1;
                end
            end else if (gap_r < `SCMG_STOP_CYC) begin
                gap_r <= gap_r + 8'h01;
            end else if (!dead_r) begin
                dead_r   <= 1'b1;
                stop_evt <= 1'b1;
            end
        end
    end
endmodule

/* verilog/scmg_top.v */
// Purpose: system clock mode guard with apb registers
// Assumes: wait_req and hw_irq come from logic on pclk
// Notes:   main_osc_input is a pin, synchronised in the watcher
//          locked or guarded writes never raise pslverr, their locked or guarded bits are dropped
//          detection events are ignored while the enable bit is low
//
// Decided for this implementation: the address map and register access over APB.
`include "scmg_regs.vh"
module scmg_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        main_osc_input,
    input  wire        wait_req,
    input  wire        hw_irq,
    output wire        cpu_clk_en,
    output reg  [1:0]  cpu_src,
    output reg         periph_src_onchip,
    output reg         periph_clk_on,
    output reg         main_osc_on,
    output reg         sub_osc_on,
    output reg         onchip_osc_on,
    output reg         pll_run,
    output reg         stop_mode,
    output reg         wait_mode,
    output reg         osc_stop_reset,
    output reg         osc_detect_irq
);
    // stored control registers
    reg  [7:0] cc0_r;
    reg  [7:0] cc1_r;
    reg  [7:0] det_r;
    reg  [7:0] pll_r;
    reg  [7:0] pm2_r;
    reg  [7:0] prc_r;

    // next values from the decode below
    reg  [7:0] cc0_nxt;
    reg  [7:0] cc1_nxt;
    reg  [7:0] det_nxt;
    reg  [7:0] pll_nxt;
    reg  [7:0] pm2_nxt;
    reg  [7:0] prc_nxt;

    // mode, detection and bus helpers
    reg        stop_nxt;
    reg        wait_nxt;
    reg        orst_nxt;
    reg        irq_nxt;
    reg  [7:0] wv;
    reg  [31:0] rd_nxt;
    reg        err_nxt;
    reg        main_src;
    reg        hs_mode;

    // watcher events and bus decode
    wire       stop_evt;
    wire       restart_evt;
    wire       lock;
    wire       wr;
    wire       setup;
    wire       div_run;

    // bus phases: answer is ready in the first access cycle
    assign setup   = psel & ~penable & ~pready;
    assign wr      = psel & penable & pwrite & pready;
    assign lock    = pm2_r[`SCMG_PM2_LOCK];
    assign div_run = ~stop_mode & ~wait_mode & ~osc_stop_reset;

    // read mux and unmapped check at setup
    always @* begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;

        case (paddr)
            `SCMG_OFF_CC0:  rd_nxt[7:0] = cc0_r;
            `SCMG_OFF_CC1:  rd_nxt[7:0] = cc1_r;
            `SCMG_OFF_DET:  rd_nxt[7:0] = det_r;
            `SCMG_OFF_PLL:  rd_nxt[7:0] = pll_r;
            `SCMG_OFF_PM2:  rd_nxt[7:0] = pm2_r;
            `SCMG_OFF_PRC:  rd_nxt[7:0] = prc_r;
            `SCMG_OFF_STAT: begin
                rd_nxt[`SCMG_ST_STOP] = stop_mode;
                rd_nxt[`SCMG_ST_WAIT] = wait_mode;
            end
            default: err_nxt = 1'b1;
        endcase
    end

    // apb answer flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & err_nxt;
            prdata  <= setup ? rd_nxt : 32'h0000_0000;
        end
    end

    // mode helpers for guarded transitions
    always @* begin
        main_src = ~cc0_r[`SCMG_CC0_SUBSEL] & ~det_r[`SCMG_DET_ONCHIP] & ~cc1_r[`SCMG_CC1_PLLSRC];
        hs_mode  = main_src & ~cc0_r[`SCMG_CC0_MSTOP];
    end

    // next state of all control registers
    always @* begin
        // hold all but irq_nxt, which defaults low, unless a write or event moves it
        cc0_nxt  = cc0_r;
        cc1_nxt  = cc1_r;
        det_nxt  = det_r;
        pll_nxt  = pll_r;
        pm2_nxt  = pm2_r;
        prc_nxt  = prc_r;
        stop_nxt = stop_mode;
        wait_nxt = wait_mode;
        orst_nxt = osc_stop_reset;
        irq_nxt  = 1'b0;

        // low byte carries the register value
        wv       = pwdata[7:0];

        if (wr && paddr == `SCMG_OFF_CC0) begin
            cc0_nxt = lock ? ((cc0_r & `SCMG_CC0_LKMASK) | (wv & ~`SCMG_CC0_LKMASK)) : wv;

            if (cc0_nxt[`SCMG_CC0_SUBSEL] && !cc0_r[`SCMG_CC0_SUBSEL] && !cc0_r[`SCMG_CC0_SUBEN])
                cc0_nxt[`SCMG_CC0_SUBSEL] = 1'b0;

            if (cc1_r[`SCMG_CC1_PLLSRC])
                cc0_nxt[`SCMG_CC0_SUBSEL] = cc0_r[`SCMG_CC0_SUBSEL];

            if (cc0_nxt[`SCMG_CC0_MSTOP])
                cc0_nxt[`SCMG_CC0_DIV8] = 1'b1;
        end

        if (wr && paddr == `SCMG_OFF_CC1) begin
            cc1_nxt = lock ? ((cc1_r & `SCMG_CC1_LKMASK) | (wv & ~`SCMG_CC1_LKMASK)) : wv;

            if (cc1_nxt[`SCMG_CC1_PLLSRC] && !cc1_r[`SCMG_CC1_PLLSRC] &&
                !(hs_mode && pll_r[`SCMG_PLL_ON]))
                cc1_nxt[`SCMG_CC1_PLLSRC] = 1'b0;

            if (cc1_nxt[`SCMG_CC1_STOP])
                stop_nxt = 1'b1;
        end

        if (wr && paddr == `SCMG_OFF_DET) begin
            det_nxt[`SCMG_DET_EN] = lock ? det_r[`SCMG_DET_EN] : wv[`SCMG_DET_EN];
            det_nxt[`SCMG_DET_RESP] = wv[`SCMG_DET_RESP];

            if (!cc1_r[`SCMG_CC1_PLLSRC] || wv[`SCMG_DET_ONCHIP])
                det_nxt[`SCMG_DET_ONCHIP] = wv[`SCMG_DET_ONCHIP];

            // flag clears on a zero write only
            if (!wv[`SCMG_DET_FLAG])
                det_nxt[`SCMG_DET_FLAG] = 1'b0;
        end

        if (wr && paddr == `SCMG_OFF_PLL && !lock)
            pll_nxt = wv;

        // lock register needs protect unlock
        if (wr && paddr == `SCMG_OFF_PM2 && prc_r[`SCMG_PRC_UNLK])
            pm2_nxt = wv;

        // protect unlock is plain read/write
        if (wr && paddr == `SCMG_OFF_PRC)
            prc_nxt = wv;

        if (wait_req && !stop_mode)
            wait_nxt = 1'b1;

        if (hw_irq && stop_mode) begin
            stop_nxt = 1'b0;
            cc1_nxt[`SCMG_CC1_STOP] = 1'b0;
            cc0_nxt[`SCMG_CC0_DIV8] = 1'b1;
        end

        if (hw_irq && wait_mode)
            wait_nxt = 1'b0;

        if (det_r[`SCMG_DET_EN] && (stop_evt || restart_evt)) begin
            if (!det_r[`SCMG_DET_RESP]) begin
                orst_nxt = 1'b1;
            end else begin
                irq_nxt = ~det_r[`SCMG_DET_FLAG];
                // flag set wins over software clear
                det_nxt[`SCMG_DET_FLAG] = 1'b1;
                // main stopped follows the last event
                det_nxt[`SCMG_DET_MSTP] = stop_evt;

                if (stop_evt && main_src)
                    det_nxt[`SCMG_DET_ONCHIP] = 1'b1;
            end
        end

        if (osc_stop_reset) begin
            cc0_nxt  = `SCMG_CC0_RST;
            cc1_nxt  = `SCMG_CC1_RST;
            det_nxt  = `SCMG_DET_RST;
            pll_nxt  = `SCMG_PLL_RST;
            pm2_nxt  = `SCMG_PM2_RST;
            prc_nxt  = `SCMG_PRC_RST;
            stop_nxt = 1'b0;
            wait_nxt = 1'b0;
            irq_nxt  = 1'b0;
        end
    end

    // control register state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc0_r          <= `SCMG_CC0_RST;
            cc1_r          <= `SCMG_CC1_RST;
            det_r          <= `SCMG_DET_RST;
            pll_r          <= `SCMG_PLL_RST;
            pm2_r          <= `SCMG_PM2_RST;
            prc_r          <= `SCMG_PRC_RST;
            stop_mode      <= 1'b0;
            wait_mode      <= 1'b0;
            osc_stop_reset <= 1'b0;
            osc_detect_irq <= 1'b0;
        end else begin
            cc0_r          <= cc0_nxt;
            cc1_r          <= cc1_nxt;
            det_r          <= det_nxt;
            pll_r          <= pll_nxt;
            pm2_r          <= pm2_nxt;
            prc_r          <= prc_nxt;
            stop_mode      <= stop_nxt;
            wait_mode      <= wait_nxt;
            osc_stop_reset <= orst_nxt;
            osc_detect_irq <= irq_nxt;
        end
    end

    // clock source and oscillator outputs from the new state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_src           <= `SCMG_SRC_MAIN;
            periph_src_onchip <= 1'b0;
            periph_clk_on     <= 1'b1;
            main_osc_on       <= 1'b1;
            sub_osc_on        <= 1'b0;
            onchip_osc_on     <= 1'b0;
            pll_run           <= 1'b0;
        end else begin
            if (cc0_nxt[`SCMG_CC0_SUBSEL])
                cpu_src <= `SCMG_SRC_SUB;
            else if (det_nxt[`SCMG_DET_ONCHIP])
                cpu_src <= `SCMG_SRC_ONCHIP;
            else if (cc1_nxt[`SCMG_CC1_PLLSRC])
                cpu_src <= `SCMG_SRC_PLL;
            else
                cpu_src <= `SCMG_SRC_MAIN;

            periph_src_onchip <= det_nxt[`SCMG_DET_ONCHIP] | det_nxt[`SCMG_DET_MSTP];
            onchip_osc_on     <= ~stop_nxt & (det_nxt[`SCMG_DET_ONCHIP] | det_nxt[`SCMG_DET_MSTP]);
            // peripherals gated in stop, and in wait when asked
            periph_clk_on     <= ~stop_nxt & ~(wait_nxt & cc0_nxt[`SCMG_CC0_PWAIT]);

            main_osc_on       <= ~stop_nxt & ~cc0_nxt[`SCMG_CC0_MSTOP];

            // sub may run in pll mode
            sub_osc_on        <= ~stop_nxt & cc0_nxt[`SCMG_CC0_SUBEN];
            // pll enable follows its control bit outside stop
            pll_run           <= ~stop_nxt & pll_nxt[`SCMG_PLL_ON];
        end
    end

    scmg_cpu_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (div_run),
        .code    ({cc0_r[`SCMG_CC0_DIV8], cc1_r[`SCMG_CC1_DIVHI], cc1_r[`SCMG_CC1_DIVLO]}),
        .tick    (cpu_clk_en)
    );

    scmg_osc_mon u_mon (
        .pclk        (pclk),
        .presetn     (presetn),
        .osc_in      (main_osc_input),
        .stop_evt    (stop_evt),
        .restart_evt (restart_evt)
    );
endmodule
